/* File: verilog/dmds_top.sv */
// Register front end for two quad output converters on a serial link
`timescale 1ns/1ps
`include "dmds_regs.svh"

module dmds_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_ff,
  output logic reg_rack_ff,
  // Serial link requests
  output logic link_valid_ff,
  output logic link_conv_ff,
  output dmds_pkg::dmds_kind_t link_kind_ff,
  output logic [1:0] link_chan_ff,
  output logic [15:0] link_code_ff,
  input wire logic link_ready,
  // Serial link completion
  input wire logic link_done,
  input wire logic [15:0] link_status,
  // Converter activity
  output logic [1:0] conv_busy_ff
);

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_int_n;

  logic [1:0] hit;
  logic [1:0] rel;
  logic [1:0][3:0] wsel;

  logic [3:0][15:0] code_ff [2];
  logic [1:0] mode_ff [2];
  logic [15:0] fault_ff [2];
  logic [1:0] fresh_ff;
  logic [1:0] auto_ff;
  logic [1:0][3:0] pend_ff;
  logic [1:0] stat_pend_ff;
  logic [1:0] upd_pend_ff;
  logic [4:0] outst_ff [2];
  logic prio_ff;

  logic [1:0] accept;
  logic [1:0][3:0] set_mask;
  logic [1:0][3:0] clr_mask;
  logic [1:0] stat_req;
  logic [1:0] fresh_clr;
  logic [1:0] req_valid;
  dmds_pkg::dmds_kind_t req_kind [2];
  logic [1:0] req_chan [2];
  logic [15:0] req_code [2];
  logic [1:0] grant;
  logic [1:0] done_c;
  logic [1:0] busy_c;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [`DMDS_FIFO_W-1:0] fifo_in_word;
  logic [`DMDS_FIFO_W-1:0] fifo_out_word;
  logic xfer_done;
  logic [31:0] nxt_rdata;

  // Address decode: converter hit and register index
  function automatic logic [2:0] dmds_decode(input logic [11:0] a);
    case (a)
      `DMDS_OFF_C0_AB: return {1'b1, `DMDS_REL_AB};
      `DMDS_OFF_C0_CD: return {1'b1, `DMDS_REL_CD};
      `DMDS_OFF_C0_ST: return {1'b1, `DMDS_REL_ST};
      `DMDS_OFF_C0_MODE: return {1'b1, `DMDS_REL_MODE};
      default: return 3'h0;
    endcase
  endfunction : dmds_decode

  // Lowest pending channel first
  function automatic logic [1:0] dmds_first(input logic [3:0] p);
    if (p[0]) begin
      return 2'h0;
    end else if (p[1]) begin
      return 2'h1;
    end else if (p[2]) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction : dmds_first

  // Status word as software sees it; request bit always reads zero
  function automatic logic [31:0] dmds_status(input logic fresh,
                                              input logic autom,
                                              input logic [15:0] flt);
    logic [31:0] w;
    w = `DMDS_WORD_RST;
    w[`DMDS_ST_FRESH] = fresh;
    w[`DMDS_ST_AUTO] = autom;
    w[15:0] = flt & `DMDS_ST_FAULT_MASK;
    return w;
  endfunction : dmds_status

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_int_n = rst_sync_ff;

  // Per converter decode of the second block at its own base
  always_comb begin
    logic [2:0] d0;
    logic [2:0] d1;
    d0 = dmds_decode(reg_addr);
    d1 = dmds_decode(reg_addr - (`DMDS_OFF_C1_AB - `DMDS_OFF_C0_AB));
    hit = {d1[2], d0[2]};
    rel = d0[2] ? d0[1:0] : d1[1:0];
    for (int c = 0; c < 2; c++) begin
      for (int r = 0; r < 4; r++) begin
        wsel[c][r] = reg_wr & hit[c] & (rel == 2'(r));
      end
    end
  end

  // Write qualification, pending set and clear masks
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      accept[c] = ~mode_ff[c][`DMDS_MODE_OPSEL];
      set_mask[c][0] = accept[c] & wsel[c][`DMDS_REL_AB] & (|reg_be[1:0]);
      set_mask[c][1] = accept[c] & wsel[c][`DMDS_REL_AB] & (|reg_be[3:2]);
      set_mask[c][2] = accept[c] & wsel[c][`DMDS_REL_CD] & (|reg_be[1:0]);
      set_mask[c][3] = accept[c] & wsel[c][`DMDS_REL_CD] & (|reg_be[3:2]);
      clr_mask[c] = 4'h0;
      if (grant[c] & (req_kind[c] == dmds_pkg::DMDS_KIND_DATA)) begin
        clr_mask[c][req_chan[c]] = 1'b1;
      end
      stat_req[c] = wsel[c][`DMDS_REL_ST] & reg_be[3]
                    & reg_wdata[`DMDS_ST_REQ];
      fresh_clr[c] = stat_req[c] | (wsel[c][`DMDS_REL_ST] & reg_be[3]
                    & reg_wdata[`DMDS_ST_FRESH]);
      done_c[c] = xfer_done & (link_conv_ff == 1'(c));
    end
  end

  // Channel codes, one half per 16-bit lane pair
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k < 4; k++) begin
          code_ff[c][k] <= `DMDS_CODE_RST;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k < 4; k++) begin
          if (set_mask[c][k]) begin
            code_ff[c][k] <= k[0] ? reg_wdata[31:16] : reg_wdata[15:0];
          end
        end
      end
    end
  end

  // Mode and automatic readback controls
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      for (int c = 0; c < 2; c++) begin
        mode_ff[c] <= `DMDS_MODE_RST;
        auto_ff[c] <= 1'b0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wsel[c][`DMDS_REL_MODE] & reg_be[0]) begin
          mode_ff[c] <= reg_wdata[1:0];
        end
        if (wsel[c][`DMDS_REL_ST] & reg_be[3]) begin
          auto_ff[c] <= reg_wdata[`DMDS_ST_AUTO];
        end
      end
    end
  end

  // Pending data requests; a new write wins over the grant clear
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pend_ff <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        pend_ff[c] <= (pend_ff[c] & ~clr_mask[c]) | set_mask[c];
      end
    end
  end

  // Pending readback and output update requests
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      stat_pend_ff <= 2'h0;
      upd_pend_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (stat_req[c] | (|clr_mask[c] & auto_ff[c])) begin
          stat_pend_ff[c] <= 1'b1;
        end else if (grant[c] & (req_kind[c] == dmds_pkg::DMDS_KIND_STAT)) begin
          stat_pend_ff[c] <= 1'b0;
        end
        if (|clr_mask[c] & ~mode_ff[c][`DMDS_MODE_UPDSEL]
            & ~mode_ff[c][`DMDS_MODE_OPSEL]) begin
          upd_pend_ff[c] <= 1'b1;
        end else if (grant[c] & (req_kind[c] == dmds_pkg::DMDS_KIND_UPD)) begin
          upd_pend_ff[c] <= 1'b0;
        end
      end
    end
  end

  // Readback fields and fresh flag; a readback wins over a clear
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      for (int c = 0; c < 2; c++) begin
        fault_ff[c] <= `DMDS_FAULT_RST;
      end
      fresh_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (done_c[c] & (link_kind_ff == dmds_pkg::DMDS_KIND_STAT)) begin
          fault_ff[c] <= link_status & `DMDS_ST_FAULT_MASK;
          fresh_ff[c] <= 1'b1;
        end else if (fresh_clr[c]) begin
          fresh_ff[c] <= 1'b0;
        end
      end
    end
  end

  // Next request of each converter: data, then readback, then update
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      req_chan[c] = dmds_first(pend_ff[c]);
      req_code[c] = code_ff[c][req_chan[c]];
      req_valid[c] = (|pend_ff[c]) | stat_pend_ff[c] | upd_pend_ff[c];
      if (|pend_ff[c]) begin
        req_kind[c] = dmds_pkg::DMDS_KIND_DATA;
      end else if (stat_pend_ff[c]) begin
        req_kind[c] = dmds_pkg::DMDS_KIND_STAT;
      end else begin
        req_kind[c] = dmds_pkg::DMDS_KIND_UPD;
      end
    end
  end

  // Alternating arbitration; a full queue stalls both converters
  assign grant[0] = fifo_in_ready & req_valid[0] & (~req_valid[1] | ~prio_ff);
  assign grant[1] = fifo_in_ready & req_valid[1] & (~req_valid[0] | prio_ff);
  assign fifo_in_word = grant[1]
    ? {1'b1, req_kind[1], req_chan[1], req_code[1]}
    : {1'b0, req_kind[0], req_chan[0], req_code[0]};

  // Priority goes to the other converter after each grant
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      prio_ff <= 1'b0;
    end else if (|grant) begin
      prio_ff <= grant[0];
    end
  end

  // Outstanding transfers per converter, queued or on the link
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      for (int c = 0; c < 2; c++) begin
        outst_ff[c] <= 5'h00;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (grant[c] & ~done_c[c]) begin
          outst_ff[c] <= outst_ff[c] + 5'h01;
        end else if (done_c[c] & ~grant[c]) begin
          outst_ff[c] <= outst_ff[c] - 5'h01;
        end
      end
    end
  end

  // Busy while anything is pending or in progress
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      busy_c[c] = req_valid[c] | (outst_ff[c] != 5'h00);
    end
  end

  // Registered busy flags
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      conv_busy_ff <= 2'h0;
    end else begin
      conv_busy_ff <= busy_c;
    end
  end

  // Read data selection; unmapped reads give zero
  always_comb begin
    nxt_rdata = `DMDS_WORD_RST;
    for (int c = 0; c < 2; c++) begin
      if (hit[c]) begin
        case (rel)
          `DMDS_REL_AB: nxt_rdata = {code_ff[c][1], code_ff[c][0]};
          `DMDS_REL_CD: nxt_rdata = {code_ff[c][3], code_ff[c][2]};
          `DMDS_REL_ST: nxt_rdata = dmds_status(fresh_ff[c], auto_ff[c],
                                                fault_ff[c]);
          `DMDS_REL_MODE: nxt_rdata = {30'h00000000, mode_ff[c]};
          default: nxt_rdata = `DMDS_WORD_RST;
        endcase
      end
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      reg_rdata_ff <= `DMDS_WORD_RST;
      reg_rack_ff <= 1'b0;
    end else begin
      reg_rack_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Request queue
  dmds_fifo #(
    .WIDTH(`DMDS_FIFO_W),
    .DEPTH(`DMDS_FIFO_D),
    .AW(`DMDS_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_int_n),
    .in_valid(|grant),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_word)
  );

  // Link engine
  dmds_link u_link (
    .mclk(mclk),
    .rst_n(rst_int_n),
    .q_valid(fifo_out_valid),
    .q_word(fifo_out_word),
    .q_pop(fifo_pop),
    .xfer_done(xfer_done),
    .link_valid_ff(link_valid_ff),
    .link_conv_ff(link_conv_ff),
    .link_kind_ff(link_kind_ff),
    .link_chan_ff(link_chan_ff),
    .link_code_ff(link_code_ff),
    .link_ready(link_ready),
    .link_done(link_done)
  );

endmodule : dmds_top

/* File: verilog/dmds_regs.svh */
// Register offsets, field positions and constants of the converter port
`ifndef DMDS_REGS_SVH
`define DMDS_REGS_SVH

// Register byte offsets
`define DMDS_OFF_C0_AB 12'h180
`define DMDS_OFF_C0_CD 12'h184
`define DMDS_OFF_C0_ST 12'h188
`define DMDS_OFF_C0_MODE 12'h18C
`define DMDS_OFF_C1_AB 12'h1B0
`define DMDS_OFF_C1_CD 12'h1B4
`define DMDS_OFF_C1_ST 12'h1B8
`define DMDS_OFF_C1_MODE 12'h1BC

// Register index within one converter
`define DMDS_REL_AB 2'h0
`define DMDS_REL_CD 2'h1
`define DMDS_REL_ST 2'h2
`define DMDS_REL_MODE 2'h3

// Status register fields
`define DMDS_ST_REQ 31
`define DMDS_ST_FRESH 30
`define DMDS_ST_AUTO 28
`define DMDS_ST_FAULT_MASK 16'hF1FF

// Mode register fields
`define DMDS_MODE_OPSEL 0
`define DMDS_MODE_UPDSEL 1

// Reset values
`define DMDS_CODE_RST 16'h0000
`define DMDS_FAULT_RST 16'h0000
`define DMDS_MODE_RST 2'h0
`define DMDS_WORD_RST 32'h00000000

// Request queue geometry
`define DMDS_FIFO_W 21
`define DMDS_FIFO_D 16
`define DMDS_FIFO_AW 4

`endif

/* File: verilog/dmds_pkg.sv */
// Types shared by the converter port modules
package dmds_pkg;

  typedef enum logic [1:0] {
    DMDS_KIND_DATA = 2'b00,
    DMDS_KIND_STAT = 2'b01,
    DMDS_KIND_UPD = 2'b10
  } dmds_kind_t;

  typedef enum logic [1:0] {
    DMDS_LINK_IDLE = 2'b00,
    DMDS_LINK_SEND = 2'b01,
    DMDS_LINK_WAIT = 2'b10
  } dmds_link_st_t;

endpackage : dmds_pkg

/* File: verilog/dmds_fifo.sv */
// Request queue with valid and ready on both sides
`timescale 1ns/1ps
`include "dmds_regs.svh"

module dmds_fifo #(
  parameter int WIDTH = `DMDS_FIFO_W,
  parameter int DEPTH = `DMDS_FIFO_D,
  parameter int AW = `DMDS_FIFO_AW
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Pointer advance with wrap at depth
  function automatic logic [AW-1:0] dmds_ptr_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction : dmds_ptr_inc

  // Honest flags from the fill count
  assign in_ready = (count_ff != (AW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= dmds_ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= dmds_ptr_inc(rd_ptr_ff);
      end
      if (push & ~pop) begin
        count_ff <= count_ff + (AW + 1)'(1);
      end else if (pop & ~push) begin
        count_ff <= count_ff - (AW + 1)'(1);
      end
    end
  end

endmodule : dmds_fifo

/* File: verilog/dmds_link.sv */
// Serial link engine: one transfer at a time toward the converters
`timescale 1ns/1ps
`include "dmds_regs.svh"

module dmds_link (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Queue side
  input wire logic q_valid,
  input wire logic [`DMDS_FIFO_W-1:0] q_word,
  output logic q_pop,
  // Completion toward the register file
  output logic xfer_done,
  // Link side
  output logic link_valid_ff,
  output logic link_conv_ff,
  output dmds_pkg::dmds_kind_t link_kind_ff,
  output logic [1:0] link_chan_ff,
  output logic [15:0] link_code_ff,
  input wire logic link_ready,
  input wire logic link_done
);

  dmds_pkg::dmds_link_st_t state_ff;
  dmds_pkg::dmds_link_st_t nxt_state;

  // Take a new request only when the link is free
  assign q_pop = (state_ff == dmds_pkg::DMDS_LINK_IDLE) & q_valid;
  assign xfer_done = (state_ff == dmds_pkg::DMDS_LINK_WAIT) & link_done;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dmds_pkg::DMDS_LINK_IDLE: begin
        if (q_valid) begin
          nxt_state = dmds_pkg::DMDS_LINK_SEND;
        end
      end
      dmds_pkg::DMDS_LINK_SEND: begin
        if (link_ready) begin
          nxt_state = dmds_pkg::DMDS_LINK_WAIT;
        end
      end
      dmds_pkg::DMDS_LINK_WAIT: begin
        if (link_done) begin
          nxt_state = dmds_pkg::DMDS_LINK_IDLE;
        end
      end
      default: begin
        nxt_state = dmds_pkg::DMDS_LINK_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= dmds_pkg::DMDS_LINK_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request strobe held until the link takes it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_valid_ff <= 1'b0;
    end else if (q_pop) begin
      link_valid_ff <= 1'b1;
    end else if (link_ready) begin
      link_valid_ff <= 1'b0;
    end
  end

  // Request fields captured from the queue head
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_conv_ff <= 1'b0;
      link_kind_ff <= dmds_pkg::DMDS_KIND_DATA;
      link_chan_ff <= 2'h0;
      link_code_ff <= `DMDS_CODE_RST;
    end else if (q_pop) begin
      link_conv_ff <= q_word[20];
      link_kind_ff <= dmds_pkg::dmds_kind_t'(q_word[19:18]);
      link_chan_ff <= q_word[17:16];
      link_code_ff <= q_word[15:0];
    end
  end

endmodule : dmds_link

/* File: verification/dmds_props.sv */
// Concurrent checks on the converter port top level
`timescale 1ns/1ps
`include "dmds_regs.svh"
module dmds_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register access
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic reg_rack_ff,
  // Link
  input wire logic link_valid_ff,
  input wire logic link_conv_ff,
  input wire dmds_pkg::dmds_kind_t link_kind_ff,
  input wire logic [15:0] link_code_ff,
  input wire logic link_ready,
  input wire logic link_done,
  input wire logic [1:0] conv_busy_ff
);
  logic fly_ff;
  logic fconv_ff;
  logic st_rd;

  // Status register read
  assign st_rd = reg_rd && (reg_addr == `DMDS_OFF_C0_ST ||
                            reg_addr == `DMDS_OFF_C1_ST);

  // Transfer taken but not yet finished
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fly_ff <= 1'b0;
      fconv_ff <= 1'b0;
    end else if (link_valid_ff && link_ready) begin
      fly_ff <= 1'b1;
      fconv_ff <= link_conv_ff;
    end else if (link_done) begin
      fly_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RACK: assert property (reg_rack_ff == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  AST_REQ_ZERO: assert property (st_rd |=> !reg_rdata_ff[31])
    else $error("status request bit reads one");
  AST_RSVD: assert property (st_rd |=> reg_rdata_ff[29] == 1'b0 &&
    reg_rdata_ff[27:16] == 12'h000 && reg_rdata_ff[11:9] == 3'h0)
    else $error("status reserved bits not zero");
  AST_HOLD: assert property (link_valid_ff && !link_ready |=>
    link_valid_ff && $stable(link_code_ff) && $stable(link_kind_ff))
    else $error("link request changed before taken");
  AST_ONE: assert property (fly_ff |-> !link_valid_ff)
    else $error("second link request while one in flight");
  AST_BUSY_FLY: assert property (fly_ff |-> conv_busy_ff[fconv_ff])
    else $error("busy low during transfer");
  AST_BUSY_REQ: assert property (
    link_valid_ff |-> conv_busy_ff[link_conv_ff])
    else $error("busy low while request waits");
  AST_DONE_IDLE: assert property (
    link_done && fly_ff |=> !link_valid_ff [*1] ##1 1'b1)
    else $error("request right after completion");
endmodule : dmds_props

/* File: verification/dmds_partner.sv */
// Behavioural converter answering link requests
`timescale 1ns/1ps
module dmds_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Requests from the port
  input wire logic link_valid,
  input wire logic link_conv,
  input wire dmds_pkg::dmds_kind_t link_kind,
  input wire logic [1:0] link_chan,
  input wire logic [15:0] link_code,
  output logic link_ready,
  output logic link_done,
  output logic [15:0] link_status,
  // Test control
  input wire logic slow,
  input wire logic [15:0] stat_word
);
  logic [1:0] st;
  logic [3:0] cnt;
  logic isstat;
  logic [20:0] logq[$];

  // Take one request, finish it after a delay
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= 2'h0;
      cnt <= 4'h0;
      link_ready <= 1'b0;
      link_done <= 1'b0;
      link_status <= 16'h0000;
    end else begin
      link_done <= 1'b0;
      link_status <= ~link_status; // No valid word outside done
      cnt <= cnt - 4'h1;
      case (st)
        2'h0: if (link_valid) begin
          st <= 2'h1;
          cnt <= slow ? 4'h4 : 4'h0;
        end
        2'h1: if (cnt == 4'h0) begin
          link_ready <= 1'b1;
          st <= 2'h2;
        end
        2'h2: begin
          link_ready <= 1'b0;
          logq.push_back({link_conv, link_kind, link_chan, link_code});
          isstat <= link_kind == dmds_pkg::DMDS_KIND_STAT;
          cnt <= slow ? 4'h9 : 4'h1;
          st <= 2'h3;
        end
        default: if (cnt == 4'h0) begin
          link_done <= 1'b1;
          link_status <= isstat ? stat_word : ~link_status;
          st <= 2'h0;
        end
      endcase
    end
  end
endmodule : dmds_partner

/* File: verification/tb.sv */
// Self-checking bench for the converter port
`timescale 1ns/1ps
`include "dmds_regs.svh"
module tb;
  localparam logic [1:0] KD = dmds_pkg::DMDS_KIND_DATA;
  localparam logic [1:0] KS = dmds_pkg::DMDS_KIND_STAT;
  localparam logic [1:0] KU = dmds_pkg::DMDS_KIND_UPD;
  logic mclk, rst_n, reg_wr, reg_rd, slow, reg_rack_ff;
  logic link_ready, link_done, link_valid_ff, link_conv_ff;
  logic [11:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata_ff, rd_v;
  logic [1:0] link_chan_ff, conv_busy_ff;
  logic [15:0] link_code_ff, link_status, stat_word;
  dmds_pkg::dmds_kind_t link_kind_ff;
  int num_errors, compares;
  int cyc = 0;

  dmds_top i_dmds_top (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_be, .reg_wdata, .reg_rdata_ff, .reg_rack_ff, .link_valid_ff,
    .link_conv_ff, .link_kind_ff, .link_chan_ff, .link_code_ff,
    .link_ready, .link_done, .link_status, .conv_busy_ff);
  dmds_partner i_dmds_partner (.mclk, .rst_n, .link_valid(link_valid_ff),
    .link_conv(link_conv_ff), .link_kind(link_kind_ff),
    .link_chan(link_chan_ff), .link_code(link_code_ff), .link_ready,
    .link_done, .link_status, .slow, .stat_word);

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("rack", {31'h0, reg_rack_ff}, 32'h1);
    rd_v = reg_rdata_ff;
  endtask : rd

  task automatic idle;
    int n;
    n = 0;
    repeat (4) @(negedge mclk);
    while (conv_busy_ff !== 2'b00 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk("busy", {30'h0, conv_busy_ff}, 32'h0);
  endtask : idle

  task automatic xf(input logic cv, input logic [1:0] k, ch,
                    input logic [15:0] cd);
    logic [20:0] m;
    logic [20:0] s;
    m = (k == KD) ? 21'h1FFFFF : 21'h1C0000;
    s = 21'h1FFFFF;
    if (i_dmds_partner.logq.size() > 0) s = i_dmds_partner.logq.pop_front();
    chk("xfer", {11'h0, s & m}, {11'h0, {cv, k, ch, cd} & m});
  endtask : xf

  task automatic t_reset;
    logic [11:0] ra[8] = '{12'h180, 12'h184, 12'h188, 12'h18C,
                           12'h1B0, 12'h1B4, 12'h1B8, 12'h1BC};
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset", rd_v, 32'h0);
    end
  endtask : t_reset

  task automatic t_data32;
    slow = 1'b1;
    wr(`DMDS_OFF_C0_AB, 4'hF, 32'h8001_7FFE);
    repeat (4) @(negedge mclk);
    chk("busy0", {31'h0, conv_busy_ff[0]}, 32'h1);
    idle;
    xf(1'b0, KD, 2'h0, 16'h7FFE);
    xf(1'b0, KD, 2'h1, 16'h8001);
    xf(1'b0, KU, 2'h0, 16'h0);
    rd(`DMDS_OFF_C0_AB);
    chk("ab", rd_v, 32'h8001_7FFE);
    slow = 1'b0;
  endtask : t_data32

  task automatic t_half;
    wr(`DMDS_OFF_C1_CD, 4'h3, 32'hAAAA_1234);
    idle;
    xf(1'b1, KD, 2'h2, 16'h1234);
    xf(1'b1, KU, 2'h0, 16'h0);
    wr(`DMDS_OFF_C1_CD, 4'hC, 32'h5678_0000);
    idle;
    xf(1'b1, KD, 2'h3, 16'h5678);
    xf(1'b1, KU, 2'h0, 16'h0);
    rd(`DMDS_OFF_C1_CD);
    chk("cd", rd_v, 32'h5678_1234);
  endtask : t_half

  task automatic t_seq;
    wr(`DMDS_OFF_C0_MODE, 4'h1, 32'h1);
    rd(`DMDS_OFF_C0_MODE);
    chk("mode", rd_v, 32'h1);
    wr(`DMDS_OFF_C0_CD, 4'hF, 32'h1111_2222);
    idle;
    chk("count", 32'(i_dmds_partner.logq.size()), 32'h0);
    rd(`DMDS_OFF_C0_CD);
    chk("cd0", rd_v, 32'h0);
    // Controlled update: data goes out, no update follows
    wr(`DMDS_OFF_C0_MODE, 4'h1, 32'h2);
    wr(`DMDS_OFF_C0_AB, 4'h3, 32'h0000_0055);
    idle;
    xf(1'b0, KD, 2'h0, 16'h0055);
    chk("noupd", 32'(i_dmds_partner.logq.size()), 32'h0);
    wr(`DMDS_OFF_C0_MODE, 4'h1, 32'h0);
  endtask : t_seq

  task automatic t_stat;
    stat_word = 16'hFFFF;
    wr(`DMDS_OFF_C0_ST, 4'h8, 32'h8000_0000);
    idle;
    xf(1'b0, KS, 2'h0, 16'h0);
    rd(`DMDS_OFF_C0_ST);
    chk("st", rd_v, 32'h4000_F1FF);
    wr(`DMDS_OFF_C0_ST, 4'h8, 32'h4000_0000);
    rd(`DMDS_OFF_C0_ST);
    chk("stclr", rd_v, 32'h0000_F1FF);
    slow = 1'b1;
    stat_word = 16'h1E5A;
    wr(`DMDS_OFF_C0_ST, 4'h8, 32'h8000_0000);
    rd(`DMDS_OFF_C0_ST);
    chk("stq", {30'h0, rd_v[31:30]}, 32'h0);
    idle;
    xf(1'b0, KS, 2'h0, 16'h0);
    rd(`DMDS_OFF_C0_ST);
    chk("st2", rd_v, 32'h4000_105A);
    slow = 1'b0;
  endtask : t_stat

  task automatic t_auto;
    wr(`DMDS_OFF_C1_ST, 4'h8, 32'h1000_0000);
    stat_word = 16'h0100;
    wr(`DMDS_OFF_C1_AB, 4'h3, 32'h0000_00C3);
    idle;
    xf(1'b1, KD, 2'h0, 16'h00C3);
    xf(1'b1, KS, 2'h0, 16'h0);
    xf(1'b1, KU, 2'h0, 16'h0);
    rd(`DMDS_OFF_C1_ST);
    chk("auto", rd_v, 32'h5000_0100);
    // Both converters pending: grants alternate between them
    wr(`DMDS_OFF_C0_AB, 4'hF, 32'h0077_0066);
    wr(`DMDS_OFF_C1_AB, 4'h3, 32'h0000_0099);
    idle;
    xf(1'b0, KD, 2'h0, 16'h0066);
    xf(1'b0, KD, 2'h1, 16'h0077);
    xf(1'b1, KD, 2'h0, 16'h0099);
    xf(1'b0, KU, 2'h0, 16'h0);
    xf(1'b1, KS, 2'h0, 16'h0);
    xf(1'b1, KU, 2'h0, 16'h0);
  endtask : t_auto

  task automatic t_rerst;
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd(`DMDS_OFF_C0_AB);
    chk("rerst_ab", rd_v, 32'h0);
    rd(`DMDS_OFF_C1_ST);
    chk("rerst_st", rd_v, 32'h0);
  endtask : t_rerst

  task automatic results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
    slow = 1'b0;
    stat_word = 16'h0000;
    num_errors = 0;
    compares = 0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset;
    t_data32;
    t_half;
    t_seq;
    t_stat;
    t_auto;
    t_rerst;
    results;
  end

  // Hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      results;
    end
  end
endmodule : tb

bind dmds_top dmds_props i_dmds_props (.mclk, .rst_n, .reg_rd, .reg_addr,
  .reg_rdata_ff, .reg_rack_ff, .link_valid_ff, .link_conv_ff,
  .link_kind_ff, .link_code_ff, .link_ready, .link_done, .conv_busy_ff);
